// file: rtl/bus_mux_config_registers.sv
/*
 Register bank of a four-channel two-wire bus multiplexer, reached by a
 two-wire slave on the upstream lines. Assumes all pins are asynchronous
 and open-drain wires are resolved outside; bit 3 of each bus vector is
 downstream bus one.
*/
// Notes on behaviour
// R01: Config bit 7 sets pin one direction.
// R02: Config bit 6 sets pin two direction.
// R03: Bit 5 clear: connect only idle-high buses.
// R04: Bit 4 picks pin one open-drain or push-pull.
// R05: Bit 3 picks pin two open-drain or push-pull.
// R06: Bit 2 enables broadcast write address response.
// R07: Bits 1:0 select stuck-low timeout length.
// R08: Switch bits set and report bus connection.
// R09: Low nibble reports downstream idle-high levels.
// R10: Idle flag is don't-care for connected bus.
// R11: Any subset of buses may be connected.
// R12: Timeout disconnects upstream from downstream buses.
// R13: Idle flags sampled when command arrives.
// R14: Refused connection clears status bit, raises alert.
// R15: Timeout raises alert, keeps switch bits.
// R16: Enable low holds defaults, ignores bus.
// R17: Writes to read-only idle bits ignored.
`timescale 1ns/1ps
`default_nettype none
`include "bus_mux_params.svh"

module bus_mux_config_registers #(
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT, // Arbitrary value
    parameter int CYC_30 = `STUCK_30MS_CYC,
    parameter int CYC_15 = `STUCK_15MS_CYC,
    parameter int CYC_7P5 = `STUCK_7P5MS_CYC
) (
    input wire logic clk_sys,                  // System clock
    input wire logic rst_n,                    // Async reset, active low
    input wire logic enable_pin,               // Device enable
    input wire logic upstream_clock_line,      // Upstream clock level
    input wire logic upstream_data_line_in,    // Upstream data level
    output logic upstream_data_line_out,       // Always low when driven
    output logic upstream_data_line_oe,        // Pull data low
    input wire logic [3:0] downstream_data_line,  // Downstream data levels
    input wire logic [3:0] downstream_clock_line, // Downstream clock levels
    output logic [3:0] switch_closed,          // Switch states
    output logic buffer_enable,                // Buffers active
    output logic ready,                        // Some bus connected, no timeout
    output logic fault_alert,                  // Pull alert low
    input wire logic general_io_pin_one_in,    // Pin one level
    output logic general_io_pin_one_out,       // Pin one drive value
    output logic general_io_pin_one_oe,        // Pin one driven
    input wire logic general_io_pin_two_in,    // Pin two level
    output logic general_io_pin_two_out,       // Pin two drive value
    output logic general_io_pin_two_oe         // Pin two driven
);
    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    logic [12:0] pins_s;
    logic en_s, scl_s, sda_s, gp1_s, gp2_s;
    logic [3:0] dsda_s, dscl_s, idle_s;

    sync2 #(.W(13)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({enable_pin, upstream_clock_line, upstream_data_line_in,
                   downstream_data_line, downstream_clock_line,
                   general_io_pin_one_in, general_io_pin_two_in}),
        .sync_out(pins_s)
    );

    assign {en_s, scl_s, sda_s, dsda_s, dscl_s, gp1_s, gp2_s} = pins_s;
    assign idle_s = dsda_s & dscl_s; // R09

    // ----------------------------------------
    // State and reset value
    // ----------------------------------------
    bus_mux_pkg::bank_state_t q, d;
    bus_mux_pkg::bank_state_t rst_val;
    logic timeout_rt, stuck_run, rise, fall, start, stop, reg_wr;
    logic [3:0] granted, refused;
    logic [7:0] rdata;

    always_comb begin
        rst_val = '0;
        rst_val.st = bus_mux_pkg::S_IDLE;
        rst_val.cfg = `CFG_RST;
        rst_val.sw = `SWITCH_RST;
        rst_val.gpo = `GPO_RST;
        rst_val.fail_n = 1'b1;
        rst_val.scl_p = 1'b1;
        rst_val.sda_p = 1'b1;
    end

    // ----------------------------------------
    // Stuck-low timer
    // ----------------------------------------
    // Common nodes are low when any connected line is low
    assign stuck_run = |(q.sw & ~idle_s);

    stuck_timer #(.CYC_30(CYC_30), .CYC_15(CYC_15), .CYC_7P5(CYC_7P5)) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(stuck_run),
        .sel(q.cfg[`CFG_TSEL_HI_BIT:`CFG_TSEL_LO_BIT]), // R07
        .timeout(timeout_rt)
    );

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        unique case (q.ptr)
            `REG_FAULT_OFS: rdata = {|q.sw, 4'h0, q.fail_n, q.tlatch, timeout_rt};
            `REG_GPIO_OFS: rdata = {2'h0, q.gpo, 2'h0, gp1_s, gp2_s};
            `REG_CFG_OFS: rdata = q.cfg;
            `REG_SWITCH_OFS: rdata = {q.sw, idle_s}; // R08 R09
            default: rdata = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Connection decision
    // ----------------------------------------
    // Flags are taken at the write itself; a connected bus keeps its
    // grant since its flag means nothing while the switch is closed.
    always_comb begin
        if (q.cfg[`CFG_CONN_ANY_BIT]) begin
            granted = q.sh[7:4]; // R03 R11
        end else begin
            granted = q.sh[7:4] & (idle_s | q.sw); // R03 R10 R13
        end
        refused = q.sh[7:4] & ~granted;
    end

    // ----------------------------------------
    // Slave sequencer and registers
    // ----------------------------------------
    always_comb begin
        d = q;
        reg_wr = 1'b0;
        rise = scl_s & ~q.scl_p;
        fall = ~scl_s & q.scl_p;
        start = scl_s & q.scl_p & q.sda_p & ~sda_s;
        stop = scl_s & q.scl_p & ~q.sda_p & sda_s;
        if (!en_s) begin
            d = rst_val; // R16
        end else if (start) begin
            d.st = bus_mux_pkg::S_ADDR;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop) begin
            d.st = bus_mux_pkg::S_IDLE;
            d.sda_oe = 1'b0;
        end else begin
            unique case (q.st)
                bus_mux_pkg::S_IDLE: begin
                    d.sda_oe = 1'b0;
                end
                bus_mux_pkg::S_ADDR, bus_mux_pkg::S_CMD, bus_mux_pkg::S_WR: begin
                    if (rise && q.cnt < 4'h8) begin
                        d.sh = {q.sh[6:0], sda_s};
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.cnt == 4'h8) begin
                        d.sda_oe = 1'b1;
                        if (q.st == bus_mux_pkg::S_ADDR) begin
                            d.rw = q.sh[0];
                            if (q.sh[7:1] == DEV_ADDR) begin
                                d.st = bus_mux_pkg::S_AACK;
                            end else if (q.sh[7:1] == `MASS_WRITE_ADDR && !q.sh[0]
                                         && q.cfg[`CFG_MASS_EN_BIT]) begin // R06
                                d.st = bus_mux_pkg::S_AACK;
                            end else begin
                                d.sda_oe = 1'b0;
                                d.st = bus_mux_pkg::S_IDLE;
                            end
                        end else if (q.st == bus_mux_pkg::S_CMD) begin
                            d.ptr = q.sh;
                            d.st = bus_mux_pkg::S_CACK;
                        end else begin
                            reg_wr = 1'b1;
                            d.st = bus_mux_pkg::S_WACK;
                        end
                    end
                end
                bus_mux_pkg::S_AACK: begin
                    if (fall) begin
                        d.cnt = 4'h0;
                        if (q.rw) begin
                            d.sh = rdata;
                            d.sda_oe = ~rdata[7];
                            d.st = bus_mux_pkg::S_RD;
                        end else begin
                            d.sda_oe = 1'b0;
                            d.st = bus_mux_pkg::S_CMD;
                        end
                    end
                end
                bus_mux_pkg::S_CACK, bus_mux_pkg::S_WACK: begin
                    if (fall) begin
                        d.sda_oe = 1'b0;
                        d.cnt = 4'h0;
                        d.st = bus_mux_pkg::S_WR;
                    end
                end
                bus_mux_pkg::S_RD: begin
                    if (rise) begin
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.cnt == 4'h8) begin
                        d.sda_oe = 1'b0;
                        d.st = bus_mux_pkg::S_RACK;
                    end else if (fall) begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.sda_oe = ~q.sh[6];
                    end
                end
                bus_mux_pkg::S_RACK: begin
                    // Master acknowledge kept in sh[0]
                    if (rise) begin
                        d.sh[0] = sda_s;
                    end else if (fall && !q.sh[0]) begin
                        d.cnt = 4'h0;
                        d.sh = rdata;
                        d.sda_oe = ~rdata[7];
                        d.st = bus_mux_pkg::S_RD;
                    end else if (fall) begin
                        d.st = bus_mux_pkg::S_IDLE;
                    end
                end
            endcase
            // Effects of a register write
            if (reg_wr) begin
                unique case (q.ptr)
                    `REG_FAULT_OFS: begin
                        d.fail_n = 1'b1;
                        d.tlatch = 1'b0;
                        d.alert = 1'b0;
                    end
                    `REG_GPIO_OFS: d.gpo = q.sh[5:4];
                    `REG_CFG_OFS: d.cfg = q.sh; // R01 R02 R04 R05 R06 R07
                    `REG_SWITCH_OFS: begin
                        d.sw = granted; // R08 R11 R17
                        if (|refused) begin
                            d.fail_n = 1'b0; // R14
                            d.alert = 1'b1;
                        end
                    end
                    default: d.cnt = 4'h0;
                endcase
            end
            // Timeout event after the write so a set wins over a clear
            if (timeout_rt && !q.to_p) begin
                d.tlatch = 1'b1; // R15
                d.alert = 1'b1;
            end
        end
        d.to_p = timeout_rt;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: bus_mux_pkg::S_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00,
                   rw: 1'b0, sda_oe: 1'b0, cfg: `CFG_RST, sw: `SWITCH_RST,
                   gpo: `GPO_RST, fail_n: 1'b1, tlatch: 1'b0, alert: 1'b0,
                   to_p: 1'b0, scl_p: 1'b1, sda_p: 1'b1};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign upstream_data_line_out = 1'b0;
    assign upstream_data_line_oe = q.sda_oe;
    assign switch_closed = q.sw; // R08
    // Timeout de-biases buffers only; switches stay as they are
    assign buffer_enable = |q.sw & ~timeout_rt; // R12 R15
    assign ready = buffer_enable;
    assign fault_alert = q.alert;

    // Open-drain releases for a one; push-pull drives whenever the pin is an output
    assign general_io_pin_one_out = q.gpo[1] & q.cfg[`CFG_GP1_PP_BIT]; // R04
    assign general_io_pin_one_oe = ~q.cfg[`CFG_GP1_DIR_BIT]
        & (q.cfg[`CFG_GP1_PP_BIT] | ~q.gpo[1]); // R01
    assign general_io_pin_two_out = q.gpo[0] & q.cfg[`CFG_GP2_PP_BIT]; // R05
    assign general_io_pin_two_oe = ~q.cfg[`CFG_GP2_DIR_BIT]
        & (q.cfg[`CFG_GP2_PP_BIT] | ~q.gpo[0]); // R02

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_enable_defaults: assert property (!en_s |=> q.cfg == `CFG_RST && q.sw == 4'h0) // R16
        else $error("controls not at default while disabled");
    chk_pin1_input: assert property (q.cfg[7] |-> !general_io_pin_one_oe) // R01
        else $error("pin one driven in input mode");
    chk_pin2_input: assert property (q.cfg[6] |-> !general_io_pin_two_oe) // R02
        else $error("pin two driven in input mode");
    chk_pin1_drain: assert property (!q.cfg[4] |-> !general_io_pin_one_out) // R04
        else $error("pin one drives high in open-drain mode");
    chk_pin2_push: assert property (q.cfg[3] && !q.cfg[6] |-> general_io_pin_two_oe) // R05
        else $error("pin two not driven in push-pull mode");
    chk_refuse_alert: assert property ($fell(q.fail_n) |-> q.alert && !q.cfg[5]) // R03 R14
        else $error("failed connection without alert or under override");
    chk_timeout_buf: assert property (timeout_rt |-> !buffer_enable) // R12
        else $error("buffers active during timeout");
    chk_timeout_alert: assert property ($rose(timeout_rt) |=> q.tlatch && q.alert) // R15
        else $error("timeout not latched");
    chk_switch_hold: assert property (!reg_wr && en_s |=> $stable(q.sw)) // R15
        else $error("switch state moved without a write");
    chk_idle_read: assert property (q.ptr == 8'h03 // R09 R17
        |-> rdata[3:0] == $past(downstream_data_line & downstream_clock_line, 2))
        else $error("idle flags misreported");
    chk_mass_off: assert property (q.st == bus_mux_pkg::S_ADDR && fall && q.cnt == 4'h8
        && q.sh[7:1] == 7'h5D && !q.cfg[2] |=> !q.sda_oe) // R06
        else $error("broadcast write acknowledged while disabled");

    cov_refused: cover property ($fell(q.fail_n));
    cov_timeout: cover property ($rose(timeout_rt));
    cov_connect: cover property ($rose(buffer_enable));
endmodule

`default_nettype wire

// file: rtl/bus_mux_params.svh
/*
 Constants of the bus multiplexer register bank: offsets, bit positions,
 reset values and stuck-low timing. Assumes nothing; definitions only.
*/
`ifndef BUS_MUX_PARAMS_SVH
`define BUS_MUX_PARAMS_SVH

// ----------------------------------------
// Register offsets (command byte values)
// ----------------------------------------
`define REG_FAULT_OFS 8'h00
`define REG_GPIO_OFS 8'h01
`define REG_CFG_OFS 8'h02
`define REG_SWITCH_OFS 8'h03

// ----------------------------------------
// Field positions of pin_and_connection_config
// ----------------------------------------
`define CFG_GP1_DIR_BIT 7
`define CFG_GP2_DIR_BIT 6
`define CFG_CONN_ANY_BIT 5
`define CFG_GP1_PP_BIT 4
`define CFG_GP2_PP_BIT 3
`define CFG_MASS_EN_BIT 2
`define CFG_TSEL_HI_BIT 1
`define CFG_TSEL_LO_BIT 0

// ----------------------------------------
// Reset values and addresses
// ----------------------------------------
`define CFG_RST 8'h04
`define SWITCH_RST 4'h0
`define GPO_RST 2'h3
`define MASS_WRITE_ADDR 7'h5D
`define DEV_ADDR_DEFAULT 7'h44

// ----------------------------------------
// Stuck-low timing
// ----------------------------------------
`define CLK_MHZ 20
`define STUCK_30MS_US 30000
`define STUCK_15MS_US 15000
`define STUCK_7P5MS_US 7500
`define STUCK_30MS_CYC (`STUCK_30MS_US * `CLK_MHZ)
`define STUCK_15MS_CYC (`STUCK_15MS_US * `CLK_MHZ)
`define STUCK_7P5MS_CYC (`STUCK_7P5MS_US * `CLK_MHZ)

`endif

// file: rtl/bus_mux_pkg.sv
/*
 Types of the bus multiplexer register bank.
 Assumes bus_mux_params.svh supplies the numbers.
*/
`default_nettype none
package bus_mux_pkg;

    // Serial slave sequencer states
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_AACK, S_CMD, S_CACK, S_WR, S_WACK, S_RD, S_RACK
    } slave_state_t;

    // Whole state of the register bank
    typedef struct packed {
        slave_state_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic rw;
        logic sda_oe;
        logic [7:0] cfg;
        logic [3:0] sw;
        logic [1:0] gpo;
        logic fail_n;
        logic tlatch;
        logic alert;
        logic to_p;
        logic scl_p;
        logic sda_p;
    } bank_state_t;

endpackage

`default_nettype wire

// file: rtl/stuck_timer.sv
/*
 Stuck-low timer: counts while the common lines are low and flags
 a timeout at the selected limit. Assumes a synchronised run input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bus_mux_params.svh"

module stuck_timer #(
    parameter int CYC_30 = `STUCK_30MS_CYC,
    parameter int CYC_15 = `STUCK_15MS_CYC,
    parameter int CYC_7P5 = `STUCK_7P5MS_CYC
) (
    input wire logic clk_sys,    // System clock
    input wire logic rst_n,      // Async reset, active low
    input wire logic run,        // A common line is low
    input wire logic [1:0] sel,  // Timeout select, 0 = off
    output logic timeout         // Timeout in progress
);
    typedef struct packed {
        logic [19:0] cnt;
        logic hit;
    } timer_state_t;

    timer_state_t q, d;
    logic [19:0] limit;

    if (CYC_30 < 1 || CYC_30 >= (1 << 20) || CYC_15 < 1 || CYC_7P5 < 1) begin : g_bad
        $error("stuck_timer limits out of range");
    end

    // Limit from the select code
    always_comb begin
        unique case (sel)
            2'h1: limit = 20'(CYC_30);
            2'h2: limit = 20'(CYC_15);
            2'h3: limit = 20'(CYC_7P5);
            2'h0: limit = 20'hFFFFF;
        endcase
    end

    // Cleared as soon as the lines go high or the timer is off
    always_comb begin
        d = q;
        if (!run || sel == 2'h0) begin
            d.cnt = 20'h00000;
            d.hit = 1'b0;
        end else if (q.cnt >= limit - 20'h00001) begin
            d.hit = 1'b1;
        end else begin
            d.cnt = q.cnt + 20'h00001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign timeout = q.hit;
endmodule

`default_nettype wire

// file: rtl/sync2.sv
/*
 Two-flop synchroniser for a vector of independent levels.
 Assumes every bit is a slow level; no bit relation is kept.
*/
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys,          // System clock
    input wire logic rst_n,            // Async reset, active low
    input wire logic [W-1:0] async_in, // Levels from outside
    output logic [W-1:0] sync_out      // Levels on clk_sys
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;

    sync_state_t q, d;

    if (W < 1) begin : g_bad_width
        $error("sync2 width must be positive");
    end

    // First stage feeds only the second
    always_comb begin
        d = q;
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    // Idle high to match released open-drain lines
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.s2;
endmodule

`default_nettype wire

// file: testbench/testbench.sv
/*
 Self-checking bench of the bus multiplexer register bank.
 Assumes up_master as upstream master and pulled-up wires.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bus_mux_params.svh"

module testbench;
    localparam logic [6:0] ADR = `DEV_ADDR_DEFAULT;
    logic clk_sys, rst_n, enable_pin, m_scl, m_oe, d_oe, buf_en, rdy, alert;
    logic g1o, g1e, g2o, g2e;
    logic [3:0] ds_sda, ds_scl, sw, k, idle, ex;
    logic [7:0] c;
    int error_cnt = 0;
    int checked = 0;
    int lim;
    wire logic sda_w = ~(m_oe | d_oe);
    wire logic g1_in = g1e ? g1o : 1'b1;
    wire logic g2_in = g2e ? g2o : 1'b1;

    up_master i_up_master (.clk_sys(clk_sys), .sda(sda_w), .scl(m_scl), .sda_oe(m_oe));
    // Short stuck-low limits keep the run brief
    bus_mux_config_registers #(.CYC_30(40), .CYC_15(20), .CYC_7P5(10))
    i_bus_mux_config_registers (
        .clk_sys(clk_sys), .rst_n(rst_n), .enable_pin(enable_pin),
        .upstream_clock_line(m_scl), .upstream_data_line_in(sda_w),
        .upstream_data_line_out(), .upstream_data_line_oe(d_oe),
        .downstream_data_line(ds_sda), .downstream_clock_line(ds_scl),
        .switch_closed(sw), .buffer_enable(buf_en), .ready(rdy), .fault_alert(alert),
        .general_io_pin_one_in(g1_in), .general_io_pin_one_out(g1o),
        .general_io_pin_one_oe(g1e), .general_io_pin_two_in(g2_in),
        .general_io_pin_two_out(g2o), .general_io_pin_two_oe(g2e));

    // ----------------------------------------
    // Expectations and checking
    // ----------------------------------------
    // Pin drive {oe, out}: output mode and either push-pull or driving low
    function automatic logic [1:0] pin_exp(input logic dir, pp, gpo);
        return {~dir & (pp | ~gpo), gpo & pp};
    endfunction
    function automatic logic lvl(input logic [1:0] p);
        return p[1] ? p[0] : 1'b1;
    endfunction
    task automatic check(input logic [7:0] seen, exp, input string what);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] o, d, input logic ea);
        logic ok;
        i_up_master.write_reg(a, o, d, ok);
        check({7'h0, ok}, {7'h0, ea}, "write ack");
    endtask
    task automatic rd(input logic [7:0] o, e);
        logic [7:0] v;
        logic ok;
        i_up_master.read_reg(ADR, o, v, ok);
        check({7'h0, ok}, 8'h01, "read ack");
        check(v, e, "read data");
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // About twice the expected run
    initial begin
        #4000000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        enable_pin = 1'b1;
        ds_sda = 4'hF;
        ds_scl = 4'hF;
        void'($urandom(32'h917EE2B2));
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check({4'h0, sw}, 8'h00, "switch reset");
        check({6'h0, g1e, g2e}, 8'h00, "pins released");
        rd(8'h02, 8'h04);
        rd(8'h03, 8'h0F);
        // Random pin settings read back and shape the pins
        repeat (6) begin
            c = 8'($urandom);
            k = 4'($urandom);
            wr(ADR, 8'h01, {2'h0, k[1:0], 4'h0}, 1'b1);
            wr(ADR, 8'h02, c, 1'b1);
            rd(8'h02, c);
            check({6'h0, g1e, g1o}, {6'h0, pin_exp(c[7], c[4], k[1])}, "pin one");
            check({6'h0, g2e, g2o}, {6'h0, pin_exp(c[6], c[3], k[0])}, "pin two");
            rd(8'h01, {2'h0, k[1:0], 2'h0, lvl(pin_exp(c[7], c[4], k[1])),
                lvl(pin_exp(c[6], c[3], k[0]))});
        end
        // Every subset under the default policy, idle levels at random
        wr(ADR, 8'h02, 8'h04, 1'b1);
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            wr(ADR, 8'h03, 8'h00, 1'b1);
            wr(ADR, 8'h00, 8'h00, 1'b1);
            ds_sda <= 4'($urandom);
            ds_scl <= 4'($urandom);
            @(posedge clk_sys);
            idle = ds_sda & ds_scl;
            ex = k & idle;
            wr(ADR, 8'h03, {k, ~idle}, 1'b1);
            check({4'h0, sw}, {4'h0, ex}, "granted");
            check({5'h0, rdy, alert, buf_en}, {5'h0, |ex, |(k & ~idle), |ex}, "alert");
            rd(8'h03, {ex, idle});
            rd(8'h00, {|ex, 4'h0, ~|(k & ~idle), 2'h0});
            ds_sda <= 4'h0;
            wr(ADR, 8'h03, {ex, 4'h0}, 1'b1);
            check({4'h0, sw}, {4'h0, ex}, "held closed");
        end
        // Override connects low buses without a fault
        wr(ADR, 8'h02, 8'h24, 1'b1);
        repeat (3) begin
            k = 4'($urandom);
            ds_sda <= 4'($urandom);
            wr(ADR, 8'h03, 8'h00, 1'b1);
            wr(ADR, 8'h00, 8'h00, 1'b1);
            wr(ADR, 8'h03, {k, 4'h0}, 1'b1);
            check({3'h0, alert, sw}, {4'h0, k}, "override");
        end
        // Stuck-low limits 40, 20 and 10 cycles
        for (int s = 1; s < 4; s++) begin
            lim = 80 >> s;
            ds_sda <= 4'hF;
            ds_scl <= 4'hF;
            wr(ADR, 8'h03, 8'h00, 1'b1);
            wr(ADR, 8'h02, 8'h04 | s[1:0], 1'b1);
            wr(ADR, 8'h00, 8'h00, 1'b1);
            wr(ADR, 8'h03, 8'h80, 1'b1);
            ds_scl[3] <= 1'b0;
            repeat (lim / 2) @(posedge clk_sys);
            check({7'h0, buf_en}, 8'h01, "before limit");
            repeat (lim / 2 + 8) @(posedge clk_sys);
            check({3'h0, alert, sw}, 8'h18, "stuck");
            check({7'h0, buf_en}, 8'h00, "stuck off");
            ds_scl[3] <= 1'b1;
            repeat (8) @(posedge clk_sys);
            rd(8'h00, 8'h86);
            check({7'h0, buf_en}, 8'h01, "recovered");
        end
        // Broadcast address, foreign address and unmapped offset
        wr(ADR, 8'h03, 8'h00, 1'b1);
        wr(`MASS_WRITE_ADDR, 8'h02, 8'h20, 1'b1);
        wr(`MASS_WRITE_ADDR, 8'h02, 8'h04, 1'b0);
        wr(ADR ^ 7'h01, 8'h02, 8'h04, 1'b0);
        rd(8'h02, 8'h20);
        wr(ADR, 8'h07, 8'hFF, 1'b1);
        rd(8'h07, 8'h00);
        // Enable low restores defaults and ignores the bus
        wr(ADR, 8'h03, 8'hF0, 1'b1);
        check({4'h0, sw}, 8'h0F, "all closed");
        enable_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({4'h0, sw}, 8'h00, "enable low");
        wr(ADR, 8'h02, 8'h20, 1'b0);
        enable_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(8'h02, 8'h04);
        report_and_stop();
    end
endmodule

`default_nettype wire

// file: testbench/up_master.sv
/*
 Upstream two-wire master model, 400 ns bit period.
 Assumes the bench resolves the pulled-up data wire.
*/
`timescale 1ns/1ps
`default_nettype none

module up_master (
    input wire logic clk_sys, // System clock
    input wire logic sda,     // Resolved data wire
    output logic scl,         // Clock line level
    output logic sda_oe       // High pulls data low
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Data moves mid-low, so it never changes while the clock is high
    task automatic bit_io(input logic b, output logic r);
        scl <= 1'b0;
        wt(2);
        sda_oe <= ~b;
        wt(2);
        scl <= 1'b1;
        wt(2);
        r = sda;
        wt(2);
    endtask
    // Start or repeated start
    task automatic start();
        scl <= 1'b0;
        wt(2);
        sda_oe <= 1'b0;
        wt(2);
        scl <= 1'b1;
        wt(4);
        sda_oe <= 1'b1;
        wt(4);
    endtask
    task automatic stop();
        scl <= 1'b0;
        wt(2);
        sda_oe <= 1'b1;
        wt(2);
        scl <= 1'b1;
        wt(4);
        sda_oe <= 1'b0;
        wt(8);
    endtask
    task automatic tx(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Any data byte, so any subset of switches, may be commanded
    task automatic write_reg(input logic [6:0] a, input logic [7:0] o, d, output logic ok);
        logic k0, k1, k2;
        start();
        tx({a, 1'b0}, k0);
        tx(o, k1);
        tx(d, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    // One byte read, ended by a nack
    task automatic read_reg(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d,
                            output logic ok);
        logic k0, k1, k2, r;
        start();
        tx({a, 1'b0}, k0);
        tx(o, k1);
        start();
        tx({a, 1'b1}, k2);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b1, r);
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule

`default_nettype wire
